/* src/phyim_edge.sv */
// phyim_edge: rising-edge detector, one lane per bit.
// assumes: inputs are synchronous levels on sys_clk_in.
module phyim_edge #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise_out
);
    import phyim_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } phyim_edge_state_t;

    phyim_edge_state_t st_q;
    phyim_edge_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // per-lane compare against last cycle
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            assign rise_out[g] = level_in[g] & ~st_q.prev[g];
        end
    endgenerate

    // next state is simply the current level
    always_comb begin
        st_d      = st_q;
        st_d.prev = level_in;
    end

    // prev starts low, so a level already high at release fires once
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

/* src/phyim_pkg.sv */
// phyim_pkg: register map, field positions and reset values for the
// low interrupt mask block and its event status.
// assumes: a 5-bit management register address and 16-bit register data.
package phyim_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h11;
    localparam logic [ADDR_W-1:0] OFS_CFG10  = 5'h1C;

    // event bit positions, shared by mask and status
    localparam int BIT_DISC_MSB   = 11;
    localparam int BIT_FCAR_MSB   = 10;
    localparam int BIT_RXERR_MSB  = 9;
    localparam int BIT_LOOP_FAULT = 8;
    localparam int BIT_RESET_DONE = 7;
    localparam int BIT_JABBER     = 6;
    localparam int BIT_AN_DONE    = 5;
    localparam int BIT_PD_FAULT   = 4;
    localparam int BIT_PD_FAIL    = 3;
    localparam int BIT_REM_FAULT  = 2;
    localparam int BIT_PAGE_RX    = 1;
    localparam int BIT_RESERVED   = 0;

    // compat mode bit inside the 10 Mb/s configuration register
    localparam int BIT_COMPAT = 0;

    // implemented mask bits and reset values
    localparam logic [DATA_W-1:0] MASK_IMPL  = 16'h0FFE;
    localparam logic [DATA_W-1:0] MASK_RESET = 16'h0080;
    localparam logic [DATA_W-1:0] STAT_RESET = 16'h0000;
    localparam logic              COMPAT_RESET = 1'b0;

endpackage

/* src/phyim_sticky.sv */
// phyim_sticky: sticky event status with clear-on-read and masked irq.
// assumes: clear_in is a one-cycle pulse from a status register read.
module phyim_sticky #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] enable_in,
    output logic      [WIDTH-1:0] status_out,
    output logic                  irq_out
);
    import phyim_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] status;
        logic             irq;
    } phyim_sticky_state_t;

    phyim_sticky_state_t st_q;
    phyim_sticky_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // set beats clear so an event landing on the read is kept
    always_comb begin
        st_d = st_q;
        if (clear_in) begin
            st_d.status = '0;
        end
        st_d.status = st_d.status | set_in;
        st_d.irq    = |(st_d.status & enable_in);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_out = st_q.status;
    assign irq_out    = st_q.irq;
endmodule

/* src/phyim_top.sv */
// phyim_top: low interrupt enable mask, event status and interrupt line.
// assumes: management host on a plain strobe port, read data one cycle
// after the read strobe; event sources are synchronous levels.
//
// Behaviour
// - enable bit 11, reset 0, disconnect counter msb sets raise irq.
// - enable bit 10, reset 0, false carrier counter msb raises irq.
// - enable bit 9, reset 0, receive error counter msb raises irq.
// - enable bit 8, reset 0, elastic buffer fault in loopback.
// - enable bit 7, reset 1, reset and calibration complete.
// - enable bit 6, reset 0, 10 Mb/s jabber detected.
// - enable bit 5, reset 0, auto-negotiation completed.
// - enable bit 4, reset 0, unstable legacy link signalling seen.
// - enable bit 3, reset 0, parallel detect on unadvertised technology.
// - enable bit 2, reset 0, remote fault from negotiation or far end.
// - enable bit 1, reset 0, every received page.
// - compat mode disables all these enables and drops writes to them.
// - disabled events still recorded in status, enabled ones assert irq.
// - status register clears when read, except bits whose event lands in the read cycle.
module phyim_top (
    input  wire logic                           sys_clk_in,
    input  wire logic                           rstn_in,
    // register port
    input  wire logic [phyim_pkg::ADDR_W-1:0]   reg_addr_in,
    input  wire logic [phyim_pkg::DATA_W-1:0]   reg_wdata_in,
    input  wire logic                           reg_wr_in,
    input  wire logic                           reg_rd_in,
    output logic      [phyim_pkg::DATA_W-1:0]   reg_rdata_out,
    // event sources, all levels
    input  wire logic                           disconnect_counter_msb_in,
    input  wire logic                           false_carrier_counter_msb_in,
    input  wire logic                           receive_error_counter_msb_in,
    input  wire logic                           elastic_overrun_in,
    input  wire logic                           elastic_underrun_in,
    input  wire logic                           remote_loopback_in,
    input  wire logic                           reset_cal_done_in,
    input  wire logic                           jabber_in,
    input  wire logic                           autoneg_done_in,
    input  wire logic                           parallel_fault_in,
    input  wire logic                           parallel_fail_in,
    input  wire logic                           remote_fault_in,
    input  wire logic                           page_received_in,
    // interrupt
    output logic                                irq_out
);
    import phyim_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] mask;
        logic              compat;
        logic [DATA_W-1:0] rdata;
    } phyim_top_state_t;

    phyim_top_state_t  st_q;
    phyim_top_state_t  st_d;

    logic [DATA_W-1:0] ev_level;
    logic [DATA_W-1:0] ev_rise;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask_eff;
    logic              wr_mask;
    logic              wr_cfg;
    logic              rd_status;

    ////////////////////////////////////////////////////////////////////////
    // event levels into their bit lanes
    always_comb begin
        ev_level = '0;
        ev_level[BIT_DISC_MSB]   = disconnect_counter_msb_in;
        ev_level[BIT_FCAR_MSB]   = false_carrier_counter_msb_in;
        ev_level[BIT_RXERR_MSB]  = receive_error_counter_msb_in;
        ev_level[BIT_LOOP_FAULT] = (elastic_overrun_in | elastic_underrun_in) & remote_loopback_in;
        ev_level[BIT_RESET_DONE] = reset_cal_done_in;
        ev_level[BIT_JABBER]     = jabber_in;
        ev_level[BIT_AN_DONE]    = autoneg_done_in;
        ev_level[BIT_PD_FAULT]   = parallel_fault_in;
        ev_level[BIT_PD_FAIL]    = parallel_fail_in;
        ev_level[BIT_REM_FAULT]  = remote_fault_in;
        ev_level[BIT_PAGE_RX]    = page_received_in;
    end

    // an event is the moment its condition becomes true, not its duration
    phyim_edge #(
        .WIDTH (DATA_W)
    ) u_edge (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .level_in   (ev_level),
        .rise_out   (ev_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // strobe decode
    assign wr_mask   = reg_wr_in & (reg_addr_in == OFS_MASK);
    assign wr_cfg    = reg_wr_in & (reg_addr_in == OFS_CFG10);
    assign rd_status = reg_rd_in & (reg_addr_in == OFS_STATUS);

    assign mask_eff = st_q.compat ? '0 : (st_q.mask & MASK_IMPL);

    // status and irq; clear pulses on the read strobe itself
    phyim_sticky #(
        .WIDTH (DATA_W)
    ) u_sticky (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .set_in     (ev_rise & MASK_IMPL),
        .clear_in   (rd_status),
        .enable_in  (mask_eff),
        .status_out (status),
        .irq_out    (irq_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // register writes and read data
    always_comb begin
        st_d = st_q;
        if (wr_mask && !st_q.compat) begin
            st_d.mask = reg_wdata_in & MASK_IMPL;
        end
        if (wr_cfg) begin
            st_d.compat = reg_wdata_in[BIT_COMPAT];
        end
        // read data stands for exactly one cycle, zero otherwise
        st_d.rdata = '0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_MASK:   st_d.rdata = mask_eff;
                OFS_STATUS: st_d.rdata = status;
                OFS_CFG10:  st_d.rdata[BIT_COMPAT] = st_q.compat;
                default:    st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q.mask   <= MASK_RESET;
            st_q.compat <= COMPAT_RESET;
            st_q.rdata  <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out = st_q.rdata;
endmodule

/* verif/phyim_bench.sv */
// phyim_bench: register-level tests of enables, status and interrupt.
// assumes: phyim_host drives the register port, events are bench levels.
module phyim_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import phyim_pkg::*;
    logic              sys_clk_in = 1'b0;
    logic              rstn_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, d;
    logic              reg_wr_in, reg_rd_in, irq_out;
    logic [11:1]       ev = '0;
    logic              und = 1'b0;
    logic              lpb = 1'b0;
    int                miscompares = 0;
    int                tests_run = 0;
    int                cyc = 0;

    always #5 sys_clk_in = ~sys_clk_in;
    phyim_host host (.sys_clk_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
    phyim_top dut (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .disconnect_counter_msb_in(ev[11]), .false_carrier_counter_msb_in(ev[10]),
        .receive_error_counter_msb_in(ev[9]), .elastic_overrun_in(ev[8]), .elastic_underrun_in(und),
        .remote_loopback_in(lpb), .reset_cal_done_in(ev[7]), .jabber_in(ev[6]), .autoneg_done_in(ev[5]),
        .parallel_fault_in(ev[4]), .parallel_fail_in(ev[3]), .remote_fault_in(ev[2]),
        .page_received_in(ev[1]), .irq_out);

    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // returns on an edge: outputs read here are those of the edge before
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, well above the roughly 180 cycles the tests need
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        host.rd(OFS_MASK, d); chk("mask reset", 16'h0080, d);
        host.rd(OFS_CFG10, d); chk("cfg reset", 16'h0000, d);
        host.rd(5'h05, d); chk("unmapped", 16'h0000, d);
        host.wr(OFS_MASK, 16'hFFFF); host.rd(OFS_MASK, d); chk("mask all", 16'h0FFE, d);
        // one enable at a time; bit 8 needs loopback active
        for (int b = 1; b < 12; b++) begin
            host.wr(OFS_MASK, 16'h0001 << b);
            lpb <= (b == 8);
            ev[b] <= 1'b1;
            tick(3); chk("irq on", 16'h0001, {15'h0000, irq_out});
            host.rd(OFS_STATUS, d); chk("status", 16'h0001 << b, d);
            ev[b] <= 1'b0;
            tick(2); chk("irq off", 16'h0000, {15'h0000, irq_out});
        end
        host.wr(OFS_MASK, 16'h0000);
        lpb <= 1'b0;
        ev[6] <= 1'b1;
        ev[8] <= 1'b1;
        tick(3); chk("irq masked", 16'h0000, {15'h0000, irq_out});
        host.rd(OFS_STATUS, d); chk("masked status", 16'h0040, d);
        host.rd(OFS_STATUS, d); chk("status cleared", 16'h0000, d);
        ev[6] <= 1'b0;
        ev[8] <= 1'b0;
        lpb <= 1'b1;
        und <= 1'b1;
        tick(2); host.rd(OFS_STATUS, d); chk("underrun", 16'h0100, d);
        und <= 1'b0;
        lpb <= 1'b0;
        // compat hides enables, drops writes, stored copy returns later
        host.wr(OFS_MASK, 16'h0FFE); host.wr(OFS_CFG10, 16'h0001);
        host.rd(OFS_MASK, d); chk("compat mask", 16'h0000, d);
        host.rd(OFS_CFG10, d); chk("compat cfg", 16'h0001, d);
        ev[6] <= 1'b1;
        tick(3); chk("compat irq", 16'h0000, {15'h0000, irq_out});
        host.wr(OFS_MASK, 16'h0000); host.wr(OFS_CFG10, 16'h0000);
        host.rd(OFS_MASK, d); chk("mask kept", 16'h0FFE, d);
        chk("irq after compat", 16'h0001, {15'h0000, irq_out});
        ev[6] <= 1'b0;
        host.wr(OFS_STATUS, 16'hFFFF); host.rd(OFS_STATUS, d); chk("status jab", 16'h0040, d);
        end_sim();
    end
endmodule

/* verif/phyim_host.sv */
// phyim_host: management host model driving the plain register port.
// assumes: read data stand only in the cycle after the read strobe.
module phyim_host (
    input  wire logic                       sys_clk_in,
    input  wire logic [phyim_pkg::DATA_W-1:0] reg_rdata_in,
    output logic      [phyim_pkg::ADDR_W-1:0] reg_addr_out,
    output logic      [phyim_pkg::DATA_W-1:0] reg_wdata_out,
    output logic                            reg_wr_out,
    output logic                            reg_rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import phyim_pkg::*;

    // idle bus at time zero
    initial begin
        reg_addr_out = '0;
        reg_wdata_out = '0;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // one-cycle write; released lines flip so stale values never pass
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b1;
        reg_addr_out <= a;
        reg_wdata_out <= v;
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~v;
    endtask

    // one-cycle read; data stand in the next cycle only, so they are
    // taken at the edge that closes it, before the flop drops them
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b1;
        reg_addr_out <= a;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge sys_clk_in);
        v = reg_rdata_in;
    endtask
endmodule

/* verif/phyim_sva.sv */
// phyim_sva: port checks for the low interrupt mask block.
// assumes: bound into phyim_top, one clock, async active-low reset.
module phyim_sva (
    input wire logic                         sys_clk_in,
    input wire logic                         rstn_in,
    input wire logic [phyim_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [phyim_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic                         reg_wr_in,
    input wire logic                         reg_rd_in,
    input wire logic [phyim_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic                         jabber_in,
    input wire logic                         irq_out
);
    import phyim_pkg::*;
    logic [DATA_W-1:0] mask_q;
    logic              compat_q;
    logic [DATA_W-1:0] eff;
    logic              unmapped;

    // shadow of the enables; compat hides them but keeps the stored copy
    assign eff = compat_q ? 16'h0000 : mask_q;
    assign unmapped = reg_addr_in != OFS_MASK && reg_addr_in != OFS_STATUS && reg_addr_in != OFS_CFG10;
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_q <= MASK_RESET;
            compat_q <= 1'b0;
        end else begin
            if (reg_wr_in && reg_addr_in == OFS_MASK && !compat_q) mask_q <= reg_wdata_in & MASK_IMPL;
            if (reg_wr_in && reg_addr_in == OFS_CFG10) compat_q <= reg_wdata_in[BIT_COMPAT];
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence mask_read_s;
        reg_rd_in && reg_addr_in == OFS_MASK;
    endsequence
    sequence jab_rise_s;
        $rose(jabber_in) && eff[BIT_JABBER] ##1 $stable(eff) && !(reg_rd_in && reg_addr_in == OFS_STATUS);
    endsequence

    ////////////////////////////////////////////////////////////////////
    mask_read_a: assert property (mask_read_s |=> reg_rdata_out == $past(eff))
        else $error("mask readback differs from written enables");
    mask_bits_a: assert property (mask_read_s |=> reg_rdata_out[0] == 1'b0 && reg_rdata_out[15:12] == 4'h0)
        else $error("reserved mask bits not zero");
    cfg_read_a: assert property (reg_rd_in && reg_addr_in == OFS_CFG10 |=> reg_rdata_out == {15'h0000, $past(compat_q)})
        else $error("config readback wrong");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    unmapped_rd_a: assert property (reg_rd_in && unmapped |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    jabber_irq_a: assert property (jab_rise_s |=> irq_out)
        else $error("enabled jabber event gave no interrupt");
    irq_masked_a: assert property (eff == 16'h0000 |=> !irq_out)
        else $error("interrupt with every enable clear");
    irq_compat_a: assert property (compat_q throughout (compat_q ##1 compat_q) |=> !irq_out)
        else $error("interrupt in compat mode");
endmodule

bind phyim_top phyim_sva u_sva (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .jabber_in, .irq_out);
